// ===== pcl_loader.sv
// Purpose: Program counter load logic with APB view of low byte and latch.
// Assumes: One instruction presented per cycle on instr; mclk at 100 MHz.
// Notes:   APB answers with pready high in the access cycle, no wait states.
`timescale 1ns/10ps
`default_nettype none
module pcl_loader (
  input  wire logic                mclk,      // Core clock.
  input  wire logic                reset_n,   // Asynchronous reset, active low.
  input  wire pcl_pkg::pcl_instr_t instr,     // Decoded instruction this cycle.
  input  wire logic                irq_req,   // Interrupt request level.
  input  wire pcl_pkg::pcl_apb_req_t apb,     // APB request signals.
  output logic [31:0]              prdata,    // APB read data.
  output logic                     pready,    // APB ready.
  output logic                     pslverr,   // APB error on unmapped address.
  output logic [pcl_pkg::PC_W-1:0] fetch_addr,// Program memory fetch address.
  output logic [pcl_pkg::DW-1:0]   wreg,      // Working register.
  output logic                     irq_taken  // Interrupt accepted this cycle.
);
  import pcl_pkg::*;

  logic [PC_W-1:0]    pc_reg;
  logic [PC_W-1:0]    pc_next;
  logic [LATCH_W-1:0] pc_high_latch_reg;
  logic [DW-1:0]      wreg_reg;
  logic [1:0]         ctrl_reg;
  logic [PC_W-1:0]    stack_reg [STACK_D];
  logic [SP_W-1:0]    sp_reg;
  logic               push;
  logic               pop;
  logic [PC_W-1:0]    push_val;
  logic [PC_W-1:0]    target;
  logic               apb_wr;
  logic               apb_rd;
  logic               latch_wr_bus;
  logic               in_table_rd;
  logic [DW-1:0]      low_sum;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  assign apb_wr = apb.psel && apb.penable && apb.pwrite;
  assign apb_rd = apb.psel && apb.penable && !apb.pwrite;
  assign latch_wr_bus = apb_wr && hit(apb.paddr, OFF_LATCH);
  assign pready = 1'b1;
  assign pslverr = apb.psel && apb.penable && !(hit(apb.paddr, OFF_LOW_BYTE) ||
                   hit(apb.paddr, OFF_LATCH) || hit(apb.paddr, OFF_PC) ||
                   hit(apb.paddr, OFF_CTRL) || hit(apb.paddr, OFF_WREG));
  assign fetch_addr = pc_reg;
  assign wreg = wreg_reg;
  assign in_table_rd = instr.valid && (instr.op == PCL_OP_TABLE_RD);
  assign low_sum = pc_reg[DW-1:0] + instr.data;

  // Call/jump target from the instruction field and latch page bits.
  always_comb begin
    target = {pc_high_latch_reg[LATCH_W-1:LATCH_PAGE_LO], instr.addr};
    if (ctrl_reg[CTRL_SMALL_MEM]) begin
      target[PC_W-1:JUMP_W] = '0;
    end
  end

  // Next counter; a counter write completes before an interrupt is taken.
  // The counter holds while no instruction is issued and no interrupt is taken.
  always_comb begin
    pc_next = pc_reg;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_reg + PC_ONE;
    if (instr.valid) begin
      unique case (instr.op)
        PCL_OP_JUMP:    pc_next = target;
        PCL_OP_CALL: begin
          pc_next = target;
          push = 1'b1;
        end
        PCL_OP_RETURN, PCL_OP_RETLIT: begin
          pc_next = stack_reg[sp_reg - 3'd1];
          pop = 1'b1;
        end
        PCL_OP_WR_LOW:  pc_next = {pc_high_latch_reg, instr.data};
        PCL_OP_ADD_LOW: pc_next = {pc_high_latch_reg, low_sum};
        PCL_OP_NEXT, PCL_OP_TABLE_RD: pc_next = pc_reg + PC_ONE;
      endcase
    end
    irq_taken = irq_req && !in_table_rd && !push && !pop;
    if (irq_taken) begin
      push_val = pc_next + PC_ONE;
      pc_next = IRQ_VECTOR;
      push = 1'b1;
    end else if (push) begin
      push_val = pc_reg + PC_ONE;
    end
  end

  // Program counter, also writable as a whole low byte over the bus.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= PC_RESET;
    end else if (apb_wr && hit(apb.paddr, OFF_LOW_BYTE)) begin
      pc_reg <= {pc_high_latch_reg, apb.pwdata[DW-1:0]};
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Return stack.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sp_reg <= '0;
      for (int i = 0; i < STACK_D; i++) begin
        stack_reg[i] <= PC_RESET;
      end
    end else if (push) begin
      stack_reg[sp_reg] <= push_val;
      sp_reg <= sp_reg + 3'd1;
    end else if (pop) begin
      sp_reg <= sp_reg - 3'd1;
    end
  end

  // Latch: five bits; variant core copies upper counter bits on call/jump.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pc_high_latch_reg <= '0;
    end else if (latch_wr_bus) begin
      pc_high_latch_reg <= apb.pwdata[LATCH_W-1:0];
    end else if (ctrl_reg[CTRL_VARIANT] && instr.valid &&
                 (instr.op == PCL_OP_CALL || instr.op == PCL_OP_JUMP)) begin
      pc_high_latch_reg <= pc_reg[PC_W-1:DW];
    end
  end

  // Working register gets the literal on a literal return.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wreg_reg <= '0;
    end else if (apb_wr && hit(apb.paddr, OFF_WREG)) begin
      wreg_reg <= apb.pwdata[DW-1:0];
    end else if (instr.valid && instr.op == PCL_OP_RETLIT) begin
      wreg_reg <= instr.data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= '0;
    end else if (apb_wr && hit(apb.paddr, OFF_CTRL)) begin
      ctrl_reg <= apb.pwdata[1:0];
    end
  end

  // Read data registered at the setup phase so it is valid in the access phase.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (apb.psel && !apb.penable && !apb.pwrite) begin
      prdata <= '0;
      if (hit(apb.paddr, OFF_LOW_BYTE)) prdata[DW-1:0] <= pc_reg[DW-1:0];
      if (hit(apb.paddr, OFF_LATCH)) prdata[LATCH_W-1:0] <= pc_high_latch_reg;
      if (hit(apb.paddr, OFF_PC)) prdata[PC_W-1:0] <= pc_reg;
      if (hit(apb.paddr, OFF_CTRL)) prdata[1:0] <= ctrl_reg;
      if (hit(apb.paddr, OFF_WREG)) prdata[DW-1:0] <= wreg_reg;
    end
  end

  a_jump_target: assert property (@(posedge mclk) disable iff (!reset_n)
    (instr.valid && instr.op == PCL_OP_JUMP && !irq_req && !apb_wr)
    |=> pc_reg[JUMP_W-1:0] == $past(instr.addr))
    else $error("jump low bits wrong");
  a_jump_page: assert property (@(posedge mclk) disable iff (!reset_n)
    (instr.valid && instr.op == PCL_OP_JUMP && !irq_req && !apb_wr && !ctrl_reg[CTRL_SMALL_MEM])
    |=> pc_reg[PC_W-1:JUMP_W] == $past(pc_high_latch_reg[LATCH_W-1:LATCH_PAGE_LO]))
    else $error("jump page bits wrong");
  a_low_write: assert property (@(posedge mclk) disable iff (!reset_n)
    (instr.valid && instr.op == PCL_OP_WR_LOW && !irq_req && !apb_wr)
    |=> pc_reg == {$past(pc_high_latch_reg), $past(instr.data)})
    else $error("low byte write wrong");
  a_add_nocarry: assert property (@(posedge mclk) disable iff (!reset_n)
    (instr.valid && instr.op == PCL_OP_ADD_LOW && !irq_req && !apb_wr)
    |=> pc_reg[PC_W-1:DW] == $past(pc_high_latch_reg))
    else $error("carry leaked upward");
  a_irq_vector: assert property (@(posedge mclk) disable iff (!reset_n)
    (irq_taken && !apb_wr) |=> pc_reg == IRQ_VECTOR && sp_reg == $past(sp_reg) + 3'd1)
    else $error("interrupt vector wrong");
  a_irq_return: assert property (@(posedge mclk) disable iff (!reset_n)
    (irq_taken && instr.valid && instr.op == PCL_OP_WR_LOW && !apb_wr)
    |=> stack_reg[$past(sp_reg)] == {$past(pc_high_latch_reg), $past(instr.data)} + PC_ONE)
    else $error("return address wrong");
  a_small_mem: assert property (@(posedge mclk) disable iff (!reset_n)
    (instr.valid && (instr.op == PCL_OP_CALL || instr.op == PCL_OP_JUMP) &&
     ctrl_reg[CTRL_SMALL_MEM] && !irq_req && !apb_wr)
    |=> pc_reg[PC_W-1:JUMP_W] == '0)
    else $error("page bits used on small memory");
  a_variant_copy: assert property (@(posedge mclk) disable iff (!reset_n)
    (ctrl_reg[CTRL_VARIANT] && instr.valid && instr.op == PCL_OP_JUMP && !latch_wr_bus)
    |=> pc_high_latch_reg == $past(pc_reg[PC_W-1:DW]))
    else $error("latch not copied");
  a_table_safe: assert property (@(posedge mclk) disable iff (!reset_n)
    in_table_rd |-> !irq_taken)
    else $error("interrupt during table read");
  a_retlit_wreg: assert property (@(posedge mclk) disable iff (!reset_n)
    (instr.valid && instr.op == PCL_OP_RETLIT && !apb_wr) |=> wreg_reg == $past(instr.data))
    else $error("literal not loaded");

  c_irq_taken: cover property (@(posedge mclk) disable iff (!reset_n) irq_taken);
  c_call_ret: cover property (@(posedge mclk) disable iff (!reset_n)
    (instr.valid && instr.op == PCL_OP_CALL) ##[1:20] (instr.valid && instr.op == PCL_OP_RETLIT));
  c_irq_on_add: cover property (@(posedge mclk) disable iff (!reset_n)
    irq_taken && instr.valid && instr.op == PCL_OP_ADD_LOW);
endmodule
`default_nettype wire

// ===== pcl_pkg.sv
// Purpose: Shared constants and types for the program counter loader.
// Assumes: 13-bit program counter, 8-bit data path, 32-bit APB.
// Notes:   Register offsets are byte addresses on APB.
`default_nettype none
package pcl_pkg;
  localparam int PC_W = 13;
  localparam int DW = 8;
  localparam int LATCH_W = 5;
  localparam int JUMP_W = 11;
  localparam int STACK_D = 8;
  localparam int SP_W = 3;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam int LATCH_PAGE_LO = 3;
  localparam logic [11:0] OFF_LOW_BYTE = 12'h000;
  localparam logic [11:0] OFF_LATCH = 12'h004;
  localparam logic [11:0] OFF_PC = 12'h008;
  localparam logic [11:0] OFF_CTRL = 12'h00C;
  localparam logic [11:0] OFF_WREG = 12'h010;
  localparam int CTRL_VARIANT = 0;
  localparam int CTRL_SMALL_MEM = 1;

  typedef enum logic [2:0] {
    PCL_OP_NEXT,
    PCL_OP_JUMP,
    PCL_OP_CALL,
    PCL_OP_RETURN,
    PCL_OP_RETLIT,
    PCL_OP_WR_LOW,
    PCL_OP_ADD_LOW,
    PCL_OP_TABLE_RD
  } pcl_op_t;

  typedef struct packed {
    logic             valid;
    pcl_op_t          op;
    logic [JUMP_W-1:0] addr;
    logic [DW-1:0]    data;
  } pcl_instr_t;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } pcl_apb_req_t;
endpackage
`default_nettype wire

// ===== pcl_progmem.sv
// Purpose: Program memory and decode stage feeding the loader.
// Assumes: Unloaded words decode as a plain advance.
// Notes:   An instruction issues only while run is high.
`timescale 1ns/10ps
`default_nettype none
module pcl_progmem (
  input  wire logic                     run,        // Issue enable.
  input  wire logic [pcl_pkg::PC_W-1:0] fetch_addr, // Fetch address.
  output var  pcl_pkg::pcl_instr_t      instr       // Decoded instruction.
);
  import pcl_pkg::*;
  pcl_instr_t mem [2**PC_W];
  initial begin
    for (int i = 0; i < 2**PC_W; i++) begin
      mem[i] = '0;
    end
  end
  task automatic put(input logic [PC_W-1:0] a, input pcl_op_t op,
                     input logic [JUMP_W-1:0] f, input logic [DW-1:0] d);
    mem[a] = '{1'b1, op, f, d};
  endtask
  assign instr = '{run, mem[fetch_addr].op, mem[fetch_addr].addr, mem[fetch_addr].data};
endmodule
`default_nettype wire

// ===== program_counter_loader_test.sv
// Purpose: Self-checking bench for the program counter loader.
// Assumes: APB answers with pready high in the access cycle; the bench still waits for pready.
// Notes:   Programs are placed in the memory model, then stepped one at a time.
`timescale 1ns/10ps
`default_nettype none
module program_counter_loader_test;
  import pcl_pkg::*;
  logic            mclk = 1'b0;
  logic            reset_n = 1'b0;
  logic            run = 1'b0;
  logic            irq_req = 1'b0;
  pcl_apb_req_t    apb = '0;
  pcl_instr_t      instr;
  logic [31:0]     prdata;
  logic            pready;
  logic            pslverr;
  logic            irq_taken;
  logic [PC_W-1:0] fetch_addr;
  logic [DW-1:0]   wreg;
  logic [31:0]     rd;
  logic            err;
  int              n_mismatch = 0;
  int              compares = 0;
  int              cycles = 0;
  always #5 mclk = ~mclk;
  pcl_loader DUT (.mclk(mclk), .reset_n(reset_n), .instr(instr), .irq_req(irq_req),
    .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_addr(fetch_addr), .wreg(wreg), .irq_taken(irq_taken));
  pcl_progmem mdl (.run(run), .fetch_addr(fetch_addr), .instr(instr));
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pc(input logic [PC_W-1:0] e);
    #1;
    chk({19'h0, fetch_addr}, {19'h0, e});
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    apb <= '{a, 1'b1, 1'b0, w, d};
    @(posedge mclk);
    apb.penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  // Points the counter at p by loading the latch, then the low byte.
  task automatic goto(input logic [PC_W-1:0] p);
    wr(OFF_LATCH, {27'h0, p[12:8]});
    wr(OFF_LOW_BYTE, {24'h0, p[7:0]});
  endtask
  task automatic step(input logic [PC_W-1:0] e);
    @(posedge mclk);
    run <= 1'b1;
    @(posedge mclk);
    run <= 1'b0;
    chk_pc(e);
  endtask
  task automatic irq_step(input logic e);
    @(posedge mclk);
    run <= 1'b1;
    irq_req <= 1'b1;
    #1;
    chk({31'h0, irq_taken}, {31'h0, e});
    @(posedge mclk);
    run <= 1'b0;
    irq_req <= 1'b0;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    chk_pc(13'h0);
    rdchk(OFF_LATCH, 32'h0);
    wr(OFF_LATCH, 32'hFFFF_FFFF);
    rdchk(OFF_LATCH, 32'h1F);
    rdchk(12'h014, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(OFF_LOW_BYTE, 32'h5A);
    chk_pc(13'h1F5A);
    rdchk(OFF_LOW_BYTE, 32'h5A);
    rdchk(OFF_PC, 32'h1F5A);
    $display("test registers done");
    goto(13'h0100);
    wr(OFF_LATCH, 32'h18);
    mdl.put(13'h100, PCL_OP_JUMP, 11'h123, 8'h0);
    mdl.put(13'h1923, PCL_OP_CALL, 11'h456, 8'h0);
    mdl.put(13'h1C56, PCL_OP_RETLIT, 11'h0, 8'hA5);
    step(13'h1923);
    step(13'h1C56);
    step(13'h1924);
    chk({24'h0, wreg}, 32'hA5);
    goto(13'h0200);
    wr(OFF_LATCH, 32'h18);
    wr(OFF_CTRL, 32'h2);
    mdl.put(13'h200, PCL_OP_JUMP, 11'h321, 8'h0);
    step(13'h0321);
    goto(13'h0A00);
    wr(OFF_LATCH, 32'h08);
    wr(OFF_CTRL, 32'h1);
    mdl.put(13'hA00, PCL_OP_JUMP, 11'h010, 8'h0);
    step(13'h0810);
    rdchk(OFF_LATCH, 32'h0A);
    wr(OFF_CTRL, 32'h0);
    $display("test jumps done");
    goto(13'h02FF);
    mdl.put(13'h2FF, PCL_OP_ADD_LOW, 11'h0, 8'h02);
    step(13'h0201);
    wr(OFF_LATCH, 32'h15);
    mdl.put(13'h201, PCL_OP_WR_LOW, 11'h0, 8'h40);
    step(13'h1540);
    goto(13'h02FF);
    wr(OFF_LATCH, 32'h03);
    step(13'h0301);
    $display("test computed done");
    goto(13'h0300);
    mdl.put(13'h300, PCL_OP_WR_LOW, 11'h0, 8'h80);
    mdl.put(IRQ_VECTOR, PCL_OP_RETURN, 11'h0, 8'h0);
    irq_step(1'b1);
    chk_pc(IRQ_VECTOR);
    step(13'h0381);
    wr(OFF_CTRL, 32'h1);
    mdl.put(13'h381, PCL_OP_TABLE_RD, 11'h0, 8'h0);
    irq_step(1'b0);
    $display("test interrupt done");
    stop_test;
  end
endmodule
`default_nettype wire
